// file: hdl/counter_array_pkg.sv
// register map and field constants for the counter array register block
package counter_array_pkg;
    localparam int          DATA_W       = 8;
    localparam int          ADDR_W       = 8;
    localparam int          NUM_MODULES  = 6;
    // printed register offsets (byte addresses; some are not multiples of 4)
    localparam logic [7:0]  OFF_CNT_LOW  = 8'hF9;
    localparam logic [7:0]  OFF_CNT_HIGH = 8'hFA;
    localparam logic [7:0]  OFF_M0_LOW   = 8'hFB;
    localparam logic [7:0]  OFF_M0_HIGH  = 8'hFC;
    localparam logic [7:0]  OFF_M1_LOW   = 8'hE9;
    localparam logic [7:0]  OFF_M1_HIGH  = 8'hEA;
    localparam logic [7:0]  OFF_M2_LOW   = 8'hEB;
    localparam logic [7:0]  OFF_M2_HIGH  = 8'hEC;
    localparam logic [7:0]  OFF_M3_LOW   = 8'hED;
    localparam logic [7:0]  OFF_M3_HIGH  = 8'hEE;
    localparam logic [7:0]  OFF_M4_LOW   = 8'hFD;
    localparam logic [7:0]  OFF_M4_HIGH  = 8'hFE;
    localparam logic [7:0]  OFF_M5_LOW   = 8'hD2;
    localparam logic [7:0]  OFF_M5_HIGH  = 8'hD3;
    // control and status registers placed in free space
    localparam logic [7:0]  OFF_CONTROL  = 8'hC0;
    localparam logic [7:0]  OFF_ENABLES  = 8'hC1;
    // control register fields
    localparam int          CTL_RUN      = 0;
    localparam int          CTL_WDTEN    = 1;
    localparam int          CTL_RELSEL   = 2;
    localparam int          CTL_LEN_LO   = 3;
    localparam int          CTL_LEN_HI   = 4;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [15:0] RST_WORD     = 16'h0000;
    localparam logic [7:0]  RST_CONTROL  = 8'h00;
    localparam logic [3:0]  RST_LENGTH   = 4'h8;
    localparam logic [7:0]  UNMAPPED_RD  = 8'h00;
endpackage : counter_array_pkg

// file: hdl/counter_array_register_access.sv
// register interface of the 16-bit counter array with six compare modules
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/10ps
module counter_array_register_access
    import counter_array_pkg::*;
#(
    parameter int MODULES = counter_array_pkg::NUM_MODULES
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    // classic wishbone slave
    input  wire logic                    cyc_i,
    input  wire logic                    stb_i,
    input  wire logic                    we_i,
    input  wire logic [counter_array_pkg::ADDR_W-1:0] adr_i,
    input  wire logic [counter_array_pkg::DATA_W-1:0] dat_i,
    input  wire logic                    sel_i,
    output logic      [counter_array_pkg::DATA_W-1:0] dat_o,
    output logic                         ack_o,
    // block outputs
    output logic      [15:0]             counterValue,
    output logic      [MODULES-1:0]      compareFunctionEnable,
    output logic      [MODULES-1:0]      compareMatch,
    output logic      [3:0]              pwmLengthBits
);
    import counter_array_pkg::*;

    // register map, byte addressed
    //   counter low byte      live bits 7:0 of the shared counter
    //   counter high byte     reads the snapshot, writes bits 15:8
    //   module n low byte     capture or reload bits 7:0 of module n
    //   module n high byte    capture or reload bits 15:8 of module n
    //   control byte          run, watchdog, reload select, length code
    //   enables byte          compare enables of all modules at once
    //
    // control byte layout
    //   bit 0     counter runs, one step per clock
    //   bit 1     watchdog on, counter bytes locked
    //   bit 2     module bytes reach the reload bank
    //   bits 4:3  length code, 8 to 11 bit cycles
    //   bits 7:5  stored and read back, no effect
    //
    // bus timing
    //   a request is taken on the first edge that sees
    //   cyc and stb high with ack low
    //   ack rises after that edge and stands one cycle
    //   with stb held, ack drops for one cycle and then rises again,
    //   so at most one request every two cycles
    //   read data is registered and holds until the next read
    //
    // counter bytes
    //   a read of the low byte also catches the upper byte,
    //   so software reads low then high for a coherent value
    //   reading high first returns whatever the last low read caught
    //   a software write wins over the running increment,
    //   so a write lands exactly as written
    //   with the watchdog on, writes are acked but dropped;
    //   software sees no error and must read back if it cares
    //
    // module bytes
    //   reload select steers reads as well as writes,
    //   so software must leave it in a known state
    //   a low write clears the compare enable, a high write sets it;
    //   writing low then high leaves the comparator armed
    //   only once the full value is in place
    //   writing high then low leaves it disarmed
    //   the enables byte can override both, a module byte write
    //   takes priority when both happen in one cycle
    //
    // comparator
    //   match is registered, so it shows one cycle after
    //   the counter meets the capture value
    //   the reload bank never takes part in the compare here
    //
    // limitations
    //   no interrupt, no capture pins, no pulse output
    //   the length code only shows on its output port
    //   byte select only gates writes; reads ignore it

    typedef logic [15:0] word_t;
    typedef logic [7:0]  offset_t;

    // module address table, indexed by module number
    function automatic offset_t lowOffset(input int idx);
        case (idx)
            0:       lowOffset = OFF_M0_LOW;
            1:       lowOffset = OFF_M1_LOW;
            2:       lowOffset = OFF_M2_LOW;
            3:       lowOffset = OFF_M3_LOW;
            4:       lowOffset = OFF_M4_LOW;
            default: lowOffset = OFF_M5_LOW;
        endcase
    endfunction : lowOffset

    function automatic offset_t highOffset(input int idx);
        case (idx)
            0:       highOffset = OFF_M0_HIGH;
            1:       highOffset = OFF_M1_HIGH;
            2:       highOffset = OFF_M2_HIGH;
            3:       highOffset = OFF_M3_HIGH;
            4:       highOffset = OFF_M4_HIGH;
            default: highOffset = OFF_M5_HIGH;
        endcase
    endfunction : highOffset

    logic        [7:0]  control;
    logic        [7:0]  snapshotHigh;
    word_t              counter;
    word_t              captureValue [MODULES];
    word_t              reloadValue  [MODULES];
    logic               busReq;
    logic               wrStrobe;
    logic               rdStrobe;
    logic               watchdogOn;
    logic               reloadSel;
    logic               running;
    logic        [7:0]  next_rdData;
    logic [MODULES-1:0] hitLow;
    logic [MODULES-1:0] hitHigh;

    // one-cycle answer; ack drops the cycle after it rose
    assign busReq   = cyc_i && stb_i && !ack_o;
    assign wrStrobe = busReq && we_i && sel_i;
    assign rdStrobe = busReq && !we_i;

    assign watchdogOn = control[CTL_WDTEN];
    assign reloadSel  = control[CTL_RELSEL];
    assign running    = control[CTL_RUN];

    // decode which module byte the current address hits
    always_comb begin
        for (int i = 0; i < MODULES; i++) begin
            hitLow[i]  = (adr_i == lowOffset(i));
            hitHigh[i] = (adr_i == highOffset(i));
        end
    end

    // bus acknowledge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= busReq;
        end
    end

    // control register: run, watchdog enable, reload select, length code
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            control <= RST_CONTROL;
        end else if (wrStrobe && adr_i == OFF_CONTROL) begin
            control <= dat_i;
        end
    end

    // shared counter; software writes locked while the watchdog runs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            counter <= RST_WORD;
        end else if (wrStrobe && adr_i == OFF_CNT_LOW && !watchdogOn) begin
            counter[7:0] <= dat_i;
        end else if (wrStrobe && adr_i == OFF_CNT_HIGH && !watchdogOn) begin
            counter[15:8] <= dat_i;
        end else if (running) begin
            counter <= counter + 16'h0001;
        end
    end

    // upper byte caught on a low-byte read so a pair reads coherently
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            snapshotHigh <= RST_BYTE;
        end else if (rdStrobe && adr_i == OFF_CNT_LOW) begin
            snapshotHigh <= counter[15:8];
        end
    end

    // per-module value storage and compare-enable side effects
    generate
        for (genvar m = 0; m < MODULES; m++) begin : gen_module
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    captureValue[m] <= RST_WORD;
                    reloadValue[m]  <= RST_WORD;
                end else if (wrStrobe && hitLow[m]) begin
                    if (reloadSel) begin
                        reloadValue[m][7:0] <= dat_i;
                    end else begin
                        captureValue[m][7:0] <= dat_i;
                    end
                end else if (wrStrobe && hitHigh[m]) begin
                    if (reloadSel) begin
                        reloadValue[m][15:8] <= dat_i;
                    end else begin
                        captureValue[m][15:8] <= dat_i;
                    end
                end
            end

            // low write clears, high write sets; order lets end enabled
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    compareFunctionEnable[m] <= 1'b0;
                end else if (wrStrobe && hitLow[m]) begin
                    compareFunctionEnable[m] <= 1'b0;
                end else if (wrStrobe && hitHigh[m]) begin
                    compareFunctionEnable[m] <= 1'b1;
                end else if (wrStrobe && adr_i == OFF_ENABLES) begin
                    compareFunctionEnable[m] <= dat_i[m];
                end
            end

            // comparator only runs while its enable is set
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    compareMatch[m] <= 1'b0;
                end else begin
                    compareMatch[m] <= compareFunctionEnable[m]
                        && (counter == captureValue[m]);
                end
            end
        end
    endgenerate

    // length code 00..11 gives 8..11 bit cycles
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pwmLengthBits <= RST_LENGTH;
        end else begin
            pwmLengthBits <= RST_LENGTH + {2'b00,
                control[CTL_LEN_HI:CTL_LEN_LO]};
        end
    end

    // read multiplexer; unmapped addresses read zero
    always_comb begin
        next_rdData = UNMAPPED_RD;
        if (adr_i == OFF_CNT_LOW) begin
            next_rdData = counter[7:0];
        end else if (adr_i == OFF_CNT_HIGH) begin
            next_rdData = snapshotHigh;
        end else if (adr_i == OFF_CONTROL) begin
            next_rdData = control;
        end else if (adr_i == OFF_ENABLES) begin
            next_rdData = 8'h00;
            next_rdData[MODULES-1:0] = compareFunctionEnable;
        end
        for (int i = 0; i < MODULES; i++) begin
            if (hitLow[i]) begin
                next_rdData = reloadSel ? reloadValue[i][7:0]
                                        : captureValue[i][7:0];
            end else if (hitHigh[i]) begin
                next_rdData = reloadSel ? reloadValue[i][15:8]
                                        : captureValue[i][15:8];
            end
        end
    end

    // read data registered with the acknowledge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dat_o <= RST_BYTE;
        end else if (rdStrobe) begin
            dat_o <= next_rdData;
        end
    end

    assign counterValue = counter;

endmodule : counter_array_register_access

// file: test/counter_array_register_access_test.sv
// self-checking bench for the counter array register block
`timescale 1ns/10ps
module counter_array_register_access_test;
    import counter_array_pkg::*;
    logic        clk = '0, reset_n = '0, cyc_i = '0, stb_i = '0, we_i = '0;
    logic        sel_i = '0, ack_o, hit;
    logic [7:0]  adr_i = '0, dat_i = '0, dat_o, lo, hi, expQ[$];
    logic [15:0] counterValue;
    logic [5:0]  compareFunctionEnable, compareMatch;
    logic [3:0]  pwmLengthBits;
    logic [7:0]  lowOff[7] = '{OFF_M0_LOW, OFF_M1_LOW, OFF_M2_LOW,
                               OFF_M3_LOW, OFF_M4_LOW, OFF_M5_LOW, OFF_CNT_LOW};
    int          miscompares = 0, compares = 0, cycles = 0;
    int          seed = 32'hC6D5415F;
    // free-running 100 MHz clock
    always #5 clk = ~clk;
    counter_array_register_access #(.MODULES(6)) u_dut (.clk(clk),
        .reset_n(reset_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o),
        .ack_o(ack_o), .counterValue(counterValue),
        .compareFunctionEnable(compareFunctionEnable),
        .compareMatch(compareMatch), .pwmLengthBits(pwmLengthBits));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    // one classic cycle, held until ack is sampled high, then released
    task automatic wb(input logic w, input logic [7:0] a, d);
        @(posedge clk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        sel_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk); while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        wb(1'b0, a, 8'h00);
    endtask : rd
    // match seen within 20 cycles or not at all
    task automatic match(input logic e);
        hit = 1'b0;
        repeat (20) @(posedge clk) hit |= compareMatch[0];
        check({15'h0000, hit}, {15'h0000, e});
    endtask : match
    // read data compared in issue order; a hang ends the run
    always @(posedge clk) begin
        cycles++;
        if (ack_o === 1'b1 && we_i === 1'b0 && expQ.size() > 0)
            check({8'h00, dat_o}, {8'h00, expQ.pop_front()});
        if (cycles == 3000) begin
            miscompares++;
            finish_test();
        end
    end
    // reset, then the scenarios in turn
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(lowOff[i], RST_BYTE);
            rd(lowOff[i] + 8'h01, RST_BYTE);
        end
        rd(8'h10, UNMAPPED_RD);
        check({12'h000, pwmLengthBits}, 16'h0008);
        // each module: enable side effects, then the reload bank
        for (int i = 0; i < 6; i++) begin
            lo = 8'($random(seed));
            hi = 8'($random(seed));
            wb(1'b1, lowOff[i] + 8'h01, hi);
            check({15'h0000, compareFunctionEnable[i]}, 16'h0001);
            wb(1'b1, lowOff[i], lo);
            check({15'h0000, compareFunctionEnable[i]}, 16'h0000);
            wb(1'b1, OFF_CONTROL, 8'h04);
            wb(1'b1, lowOff[i], ~lo);
            wb(1'b1, lowOff[i] + 8'h01, ~hi);
            rd(lowOff[i], ~lo);
            rd(lowOff[i] + 8'h01, ~hi);
            wb(1'b1, OFF_CONTROL, 8'h00);
            rd(lowOff[i], lo);
            rd(lowOff[i] + 8'h01, hi);
        end
        for (int k = 0; k < 4; k++) begin
            wb(1'b1, OFF_CONTROL, 8'(k * 8));
            repeat (2) @(posedge clk);
            check({12'h000, pwmLengthBits}, 16'(k + 8));
        end
        // snapshot moves only on low reads; watchdog drops counter writes
        wb(1'b1, OFF_CONTROL, 8'h00);
        wb(1'b1, OFF_CNT_LOW, 8'h34);
        wb(1'b1, OFF_CNT_HIGH, 8'h12);
        rd(OFF_CNT_HIGH, 8'h00);
        rd(OFF_CNT_LOW, 8'h34);
        wb(1'b1, OFF_CNT_HIGH, 8'h56);
        rd(OFF_CNT_HIGH, 8'h12);
        wb(1'b1, OFF_CONTROL, 8'h02);
        wb(1'b1, OFF_CNT_LOW, 8'($random(seed)));
        wb(1'b1, OFF_CNT_HIGH, 8'($random(seed)));
        rd(OFF_CNT_LOW, 8'h34);
        rd(OFF_CNT_HIGH, 8'h56);
        check(counterValue, 16'h5634);
        // running counter meets module 0 only while it is enabled
        wb(1'b1, OFF_CONTROL, 8'h00);
        wb(1'b1, OFF_M0_LOW, 8'h05);
        wb(1'b1, OFF_M0_HIGH, 8'h00);
        wb(1'b1, OFF_CNT_HIGH, 8'h00);
        wb(1'b1, OFF_CNT_LOW, 8'h00);
        wb(1'b1, OFF_CONTROL, 8'h01);
        match(1'b1);
        wb(1'b1, OFF_M0_LOW, 8'h05);
        wb(1'b1, OFF_CNT_LOW, 8'h00);
        match(1'b0);
        finish_test();
    end
endmodule : counter_array_register_access_test

// file: test/counter_array_sva.sv
// assertions on the counter array register block ports
`timescale 1ns/10ps
module counter_array_sva
    import counter_array_pkg::*;
#(parameter int MODULES = 6) (
    // bus side
    input wire logic               clk,
    input wire logic               reset_n,
    input wire logic               cyc_i,
    input wire logic               stb_i,
    input wire logic               we_i,
    input wire logic [7:0]         adr_i,
    input wire logic [7:0]         dat_i,
    input wire logic               sel_i,
    input wire logic [7:0]         dat_o,
    input wire logic               ack_o,
    // block outputs
    input wire logic [15:0]        counterValue,
    input wire logic [MODULES-1:0] compareFunctionEnable,
    input wire logic [MODULES-1:0] compareMatch,
    input wire logic [3:0]         pwmLengthBits
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    logic       wr, rd, hold;
    logic [7:0] ctl, snap;
    assign wr   = cyc_i && stb_i && !ack_o && we_i && sel_i;
    assign rd   = cyc_i && stb_i && !ack_o && !we_i;
    assign hold = ctl[1] && !ctl[0]; // a running counter moves anyway
    // shadows of the control byte and of the high-byte snapshot
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl  <= 8'h00;
            snap <= 8'h00;
        end else begin
            if (wr && adr_i == OFF_CONTROL) ctl <= dat_i;
            if (rd && adr_i == OFF_CNT_LOW) snap <= counterValue[15:8];
        end
    end
    a_low_read: assert property (rd && adr_i == OFF_CNT_LOW
        |=> dat_o == $past(counterValue[7:0])) else $error("low read");
    a_snap_read: assert property (rd && adr_i == OFF_CNT_HIGH
        |=> dat_o == snap) else $error("snapshot read");
    a_low_lock: assert property (wr && hold && adr_i == OFF_CNT_LOW
        |=> $stable(counterValue)) else $error("locked low");
    a_high_lock: assert property (wr && hold && adr_i == OFF_CNT_HIGH
        |=> $stable(counterValue)) else $error("locked high");
    a_low_clears: assert property (wr && adr_i == OFF_M0_LOW
        |=> !compareFunctionEnable[0]) else $error("enable kept");
    a_high_sets: assert property (wr && adr_i == OFF_M0_HIGH
        |=> compareFunctionEnable[0]) else $error("enable not set");
    a_length_code: assert property (wr && adr_i == OFF_CONTROL
        |=> ##2 pwmLengthBits == 4'h8 + $past(dat_i[4:3], 3))
        else $error("length code");
    a_match_cause: assert property (compareMatch[0]
        |-> $past(compareFunctionEnable[0])) else $error("match no enable");
    c_snap: cover property (rd && adr_i == OFF_CNT_HIGH);
    c_lock: cover property (wr && hold);
    c_match: cover property (compareMatch[0]);
endmodule : counter_array_sva

bind counter_array_register_access counter_array_sva #(.MODULES(MODULES))
    u_sva (.clk(clk), .reset_n(reset_n), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o),
    .ack_o(ack_o), .counterValue(counterValue),
    .compareFunctionEnable(compareFunctionEnable),
    .compareMatch(compareMatch), .pwmLengthBits(pwmLengthBits));
